/* File: video_memory_config_regs.sv */
// Behaviour
// - At power-on reset capture memory-size bits 1:0 inverted from memory data pins.
// - Memory-size bits 7:6 give installed memory and DRAM address organisation.
// - Standard-mapping override bit forces plain VGA mapping regardless of size bits.
// - Memory-size bits 5:4 select host decode window in system space.
// - Memory-size bit 3 enables alternate offset register, two offset windows.
// - Memory-size bit 2 enables 16-bit host video memory data path.
// - Memory-size bit 1 selects 16-bit BIOS ROM path; pull-up clears it.
// - Memory-size bit 0 maps BIOS ROM out; pull-up clears it.
// - Primary offset is default; with alternate enabled, primary serves A15=1.
// - Standard word mode host DRAM bit 0 from inverted page select if chained.
// - Standard word mode CRT DRAM bit 0 from CA13 or CA15 per mode bit.
// - 512KB mode ninth address output is bank select from host bit 16, or from CA16 on CRT cycles.
// - 1024KB mode ninth address output drives DRAM address pin 8 directly.
// - 1024KB mode maps host and character bits per byte, word, dword.
// - Font plane select from map bit, underline bit and attribute bit four.
// - Page-mode addressing bit overrides character plane selection.
// - Character clock bits 4:3 select text width; none in graphics.
// - Ten-dot panning maps 9 to 0, 8 to 1, 0..7 to 2..9.
// - Underline bit underlines odd attributes, forces background bit four low.
// - Video select bit 1 drives clock line or freezes internal clock mux.
// - Video select bit 0 sets CRTC horizontal timing rate.
// - CRTC write protection uses lock bits 5,0 and CRTC reg 11 bit 7; lock bit 1 is not used.
// - Seven-bit offset added to host bits 19:12 giving 20-bit address.
// - Registers locked after reset; writable only while unlock low bits are 101.
// - Extended registers reset to zero except pin-captured bits.
// - Horizontal CRTC regs 0-5 locked if lock bit 5 or reg 11 bit 7.
`timescale 1ns/10ps
module video_memory_config_regs
  import vmcfg_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 reset,
  // Indexed data port
  input  wire logic [7:0]           regIndex,
  input  wire logic                 regWrite,
  input  wire logic                 regRead,
  input  wire logic [7:0]           regWdata,
  output logic      [7:0]           regRdata,
  // Strap pins
  input  wire logic [1:0]           memory_data_pins,
  // Context from other register groups
  input  wire logic                 misc_control_one_page,
  input  wire logic                 misc_control_two_std,
  input  wire logic [1:0]           graphics_misc_chain,
  input  wire logic                 inverted_page_select,
  input  wire logic                 crtc_mode_control,
  input  wire logic                 crtc_reg11_bit7,
  input  wire logic                 config_clock_source_bit,
  input  wire logic                 textMode,
  input  wire logic                 attribute_bit_four,
  input  wire logic [3:0]           panValue,
  input  wire logic [1:0]           accMode,
  input  wire logic [19:0]          hostAddr,
  input  wire logic [17:0]          char_address_counter,
  input  wire logic                 crtCycle,
  // Decoded outputs
  output logic      [19:0]          videoAddr,
  output logic      [17:0]          dram_address_out,
  output logic                      bank_or_high_addr_out,
  output logic                      fontPlane3,
  output logic      [3:0]           panShift,
  output logic                      bgBit4,
  output logic                      horizLocked,
  output logic                      crtc07Locked,
  output vmcfg_mem_cfg_t            memCfg,
  output vmcfg_vid_cfg_t            vidCfg
);

  // ----------------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------------
  logic [1:0] strapS0_reg, strapS1_reg, strapS2_reg;
  logic       strapDone_reg;

  // Three-stage synchroniser; only stages two and three are compared
  always_ff @(posedge clk)
  begin
    strapS0_reg <= memory_data_pins;
    strapS1_reg <= strapS0_reg;
    strapS2_reg <= strapS1_reg;
  end

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [6:0] primary_offset_reg;
  logic [6:0] alternate_offset_reg;
  logic [7:0] memory_size_reg;
  logic [7:0] video_select_reg;
  logic [7:0] crt_lock_reg;
  logic [7:0] video_control_reg;
  logic [2:0] unlock_reg;
  logic       unlocked;
  logic       wrEn;

  assign unlocked = (unlock_reg == UNLOCK_KEY);
  assign wrEn     = regWrite & unlocked;

  // Unlock key: any other value relocks
  always_ff @(posedge clk)
  begin
    if (reset)
      unlock_reg <= REG_RESET_VALUE[2:0];
    else if (regWrite && regIndex == IDX_UNLOCK)
      unlock_reg <= regWdata[2:0];
  end

  // Offset registers, seven bits wide
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      primary_offset_reg   <= REG_RESET_VALUE[6:0];
      alternate_offset_reg <= REG_RESET_VALUE[6:0];
    end
    else if (wrEn)
    begin
      if (regIndex == IDX_PRIMARY_OFFSET)
        primary_offset_reg <= regWdata[6:0];
      if (regIndex == IDX_ALTERNATE_OFFSET)
        alternate_offset_reg <= regWdata[6:0];
    end
  end

  // Strap bits are taken once after release, when the synchroniser has settled
  always_ff @(posedge clk)
  begin
    if (reset)
      strapDone_reg <= 1'b0;
    else if (strapS1_reg == strapS2_reg)
      strapDone_reg <= 1'b1;
  end

  // Memory size; pull-up reads as zero, so captured bits are inverted
  always_ff @(posedge clk)
  begin
    if (reset)
      memory_size_reg <= REG_RESET_VALUE;
    else if (!strapDone_reg && strapS1_reg == strapS2_reg)
      memory_size_reg[1:0] <= ~strapS2_reg;
    else if (wrEn && regIndex == IDX_MEMORY_SIZE)
      memory_size_reg <= regWdata;
  end

  // Video select, lock control and video control
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      video_select_reg  <= REG_RESET_VALUE;
      crt_lock_reg      <= REG_RESET_VALUE;
      video_control_reg <= REG_RESET_VALUE;
    end
    else if (wrEn)
    begin
      if (regIndex == IDX_VIDEO_SELECT)
        video_select_reg <= regWdata;
      if (regIndex == IDX_CRT_LOCK)
        crt_lock_reg <= regWdata;
      if (regIndex == IDX_VIDEO_CONTROL)
        video_control_reg <= regWdata;
    end
  end

  // Read port; the whole bank hides behind the read-protect bit, unmapped reads zero
  always_ff @(posedge clk)
  begin
    if (reset)
      regRdata <= REG_RESET_VALUE;
    else if (regRead)
    begin
      if (video_control_reg[VCT_READ_PROT_BIT])
        regRdata <= 8'h00;
      else
        case (regIndex)
          IDX_PRIMARY_OFFSET:   regRdata <= {1'b0, primary_offset_reg};
          IDX_ALTERNATE_OFFSET: regRdata <= {1'b0, alternate_offset_reg};
          IDX_MEMORY_SIZE:      regRdata <= memory_size_reg;
          IDX_VIDEO_SELECT:     regRdata <= video_select_reg;
          IDX_CRT_LOCK:         regRdata <= crt_lock_reg;
          IDX_VIDEO_CONTROL:    regRdata <= video_control_reg;
          IDX_UNLOCK:           regRdata <= {5'h00, unlock_reg};
          default:              regRdata <= 8'h00;
        endcase
    end
  end

  // ----------------------------------------------------------------------
  // Host address offset
  // ----------------------------------------------------------------------
  logic [6:0] selOffset;
  logic [7:0] pageSum;

  // Alternate window serves A15=0 only when enabled
  always_comb
  begin
    if (memory_size_reg[MSZ_ALT_EN_BIT] && !hostAddr[15])
      selOffset = alternate_offset_reg;
    else
      selOffset = primary_offset_reg;
    // Carry from the page sum reaches bit 19; beyond that the address wraps
    pageSum = hostAddr[19:12] + {1'b0, selOffset};
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      videoAddr <= 20'h00000;
    else
      videoAddr <= {pageSum, hostAddr[11:0]};
  end

  // ----------------------------------------------------------------------
  // DRAM address multiplexing
  // ----------------------------------------------------------------------
  vmcfg_size_t sizeMode;
  logic [17:0] maNext;
  logic        ma8Next;
  logic [17:0] ca;
  logic [19:0] a;

  // Override forces standard organisation, a simplification that ignores size bits
  assign sizeMode = misc_control_two_std ? MEM_STD256
                                         : vmcfg_size_t'(memory_size_reg[7:6]);
  assign ca = char_address_counter;
  assign a  = videoAddr;

  always_comb
  begin
    maNext  = 18'h00000;
    ma8Next = 1'b0;
    case (sizeMode)
      MEM_STD256, MEM_EXT256:
      begin
        if (crtCycle)
          case (accMode)
            ACC_WORD:  maNext = {2'h0, ca[14:0],
                                 crtc_mode_control ? ca[15] : ca[13]};
            ACC_DWORD: maNext = {2'h0, ca[13:0], ca[13], ca[12]};
            default:   maNext = {2'h0, ca[15:0]};
          endcase
        else
          case (accMode)
            ACC_WORD:  maNext = {2'h0, a[15:1], (sizeMode == MEM_STD256 &&
                                 |graphics_misc_chain) ? inverted_page_select : a[16]};
            ACC_DWORD: maNext = {2'h0, a[15:2], a[15], a[14]};
            default:   maNext = {2'h0, a[15:0]};
          endcase
      end
      MEM_EXT512:
      begin
        ma8Next = crtCycle ? ca[16] : a[16];
        maNext  = crtCycle ? {2'h0, ca[15:0]} : {2'h0, a[15:0]};
      end
      MEM_EXT1024:
      begin
        if (crtCycle)
          case (accMode)
            ACC_WORD:  maNext = {ca[16:0], ca[17]};
            ACC_DWORD: maNext = {ca[15:0], ca[17:16]};
            default:   maNext = ca;
          endcase
        else
          case (accMode)
            ACC_WORD:  maNext = {a[17:1], a[18]};
            ACC_DWORD: maNext = {a[17:2], a[19:18]};
            default:   maNext = a[17:0];
          endcase
        ma8Next = maNext[8];
      end
      default: maNext = 18'h00000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      dram_address_out      <= 18'h00000;
      bank_or_high_addr_out <= 1'b0;
    end
    else
    begin
      dram_address_out      <= maNext;
      bank_or_high_addr_out <= ma8Next;
    end
  end

  // ----------------------------------------------------------------------
  // Text attributes, font and panning
  // ----------------------------------------------------------------------
  logic       planeNext;
  logic [3:0] panNext;

  always_comb
  begin
    if (misc_control_one_page)
      planeNext = 1'b0;
    else if (!video_select_reg[VSL_MAP_SEL_BIT])
      planeNext = 1'b0;
    else if (!video_select_reg[VSL_UNDERLINE_BIT])
      planeNext = 1'b1;
    else
      planeNext = attribute_bit_four;
    // Ten-dot panning only applies in text modes
    if (textMode && video_select_reg[4:3] == 2'h3)
      panNext = (panValue == 4'h9) ? 4'h0 : (panValue == 4'h8) ? 4'h1
              : (panValue + 4'h2);
    else
      panNext = panValue;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      fontPlane3 <= 1'b0;
      panShift   <= 4'h0;
      bgBit4     <= 1'b0;
    end
    else
    begin
      fontPlane3 <= planeNext;
      panShift   <= panNext;
      bgBit4     <= attribute_bit_four & ~video_select_reg[VSL_UNDERLINE_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Configuration and lock outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      memCfg       <= '0;
      vidCfg       <= '0;
      horizLocked  <= 1'b0;
      crtc07Locked <= 1'b0;
    end
    else
    begin
      memCfg.hostMap      <= misc_control_two_std ? 2'h0 : memory_size_reg[5:4];
      memCfg.altOffsetEn  <= memory_size_reg[MSZ_ALT_EN_BIT];
      memCfg.bus16En      <= memory_size_reg[MSZ_BUS16_BIT];
      memCfg.rom16En      <= memory_size_reg[MSZ_ROM16_BIT];
      memCfg.romMappedOut <= memory_size_reg[MSZ_ROM_OFF_BIT];
      memCfg.standardMap  <= misc_control_two_std;
      vidCfg.charWidth    <= textMode ? video_select_reg[4:3] : 2'h0;
      vidCfg.underlineEn  <= video_select_reg[VSL_UNDERLINE_BIT];
      vidCfg.clockSel2    <= config_clock_source_bit & video_select_reg[VSL_CLK_SEL_BIT];
      vidCfg.clockMuxFreeze <= ~config_clock_source_bit & video_select_reg[VSL_CLK_SEL_BIT];
      vidCfg.horizHighRate <= video_select_reg[VSL_HRATE_BIT];
      horizLocked  <= crt_lock_reg[LCK_HORIZ_BIT] | crtc_reg11_bit7;
      crtc07Locked <= crtc_reg11_bit7 | crt_lock_reg[LCK_VERT_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence unlockSeq;
    regWrite && regIndex == IDX_UNLOCK && regWdata[2:0] == UNLOCK_KEY;
  endsequence

  chk_locked_no_write: assert property (@(posedge clk) disable iff (reset)
    (regWrite && !unlocked && regIndex == IDX_VIDEO_SELECT) |=> $stable(video_select_reg))
    else $error("video select changed while locked");
  chk_unlock_then_write: assert property (@(posedge clk) disable iff (reset)
    unlockSeq ##2 (regWrite && regIndex == IDX_CRT_LOCK) |=> crt_lock_reg == $past(regWdata))
    else $error("write after unlock not taken");
  chk_offset_sum: assert property (@(posedge clk) disable iff (reset)
    !memory_size_reg[MSZ_ALT_EN_BIT] |=>
    videoAddr[18:12] == $past(hostAddr[18:12]) + $past(primary_offset_reg))
    else $error("primary offset sum wrong");
  chk_alt_window: assert property (@(posedge clk) disable iff (reset)
    (memory_size_reg[MSZ_ALT_EN_BIT] && !hostAddr[15]) |=>
    videoAddr[18:12] == $past(hostAddr[18:12]) + $past(alternate_offset_reg))
    else $error("alternate offset not used");
  chk_pan_ten_dot: assert property (@(posedge clk) disable iff (reset)
    (textMode && video_select_reg[4:3] == 2'h3 && panValue == 4'h9) |=> panShift == 4'h0)
    else $error("ten-dot pan of nine not zero");
  chk_font_page: assert property (@(posedge clk) disable iff (reset)
    misc_control_one_page |=> !fontPlane3)
    else $error("page mode did not override font plane");
  chk_horiz_lock: assert property (@(posedge clk) disable iff (reset)
    crt_lock_reg[LCK_HORIZ_BIT] |=> horizLocked)
    else $error("horizontal lock missing");
  chk_underline_bg: assert property (@(posedge clk) disable iff (reset)
    video_select_reg[VSL_UNDERLINE_BIT] |=> !bgBit4)
    else $error("background bit four not forced");
  chk_ma8_bank: assert property (@(posedge clk) disable iff (reset)
    (sizeMode == MEM_EXT512 && !crtCycle) |=> bank_or_high_addr_out == $past(a[16]))
    else $error("bank select wrong");

endmodule // video_memory_config_regs

/* File: video_memory_config_regs_test.sv */
`timescale 1ns/10ps
module video_memory_config_regs_test;
  import vmcfg_pkg::*;
  typedef struct {int id; logic [19:0] exp; string name;} vmcfg_note_t;
  logic clk, reset, page, stdMap, pageSel, modeCtl, r11, cfgBit, textMode, att4, crtCycle;
  logic [1:0] chain, accMode;
  logic [3:0] panValue, panShift;
  logic [19:0] hostAddr, videoAddr, exp20;
  logic [17:0] charAddr, dramAddr;
  logic [7:0] regIndex, regWdata, regRdata, v, ofsA, ofsB;
  logic regWrite, regRead, ma8, font3, bg4, hLock, vLock, readDue, probe;
  logic [1:0] pins;
  vmcfg_mem_cfg_t memCfg;
  vmcfg_vid_cfg_t vidCfg;
  vmcfg_note_t notes[$];
  vmcfg_note_t note;
  int errors, testsRun;

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  vmcfg_host_model host_u (.clk(clk), .regIndex(regIndex), .regWrite(regWrite),
    .regRead(regRead), .regWdata(regWdata), .memory_data_pins(pins));

  video_memory_config_regs dut_u (.clk(clk), .reset(reset), .regIndex(regIndex),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
    .memory_data_pins(pins), .misc_control_one_page(page), .misc_control_two_std(stdMap),
    .graphics_misc_chain(chain), .inverted_page_select(pageSel),
    .crtc_mode_control(modeCtl), .crtc_reg11_bit7(r11), .config_clock_source_bit(cfgBit),
    .textMode(textMode), .attribute_bit_four(att4), .panValue(panValue),
    .accMode(accMode), .hostAddr(hostAddr), .char_address_counter(charAddr),
    .crtCycle(crtCycle), .videoAddr(videoAddr), .dram_address_out(dramAddr),
    .bank_or_high_addr_out(ma8), .fontPlane3(font3), .panShift(panShift), .bgBit4(bg4),
    .horizLocked(hLock), .crtc07Locked(vLock), .memCfg(memCfg), .vidCfg(vidCfg));

  // ----------------------------------------------------------------------
  // Watcher: takes the oldest note when a result is due
  // ----------------------------------------------------------------------
  function automatic logic [19:0] obs(input int id);
    case (id)
      0: obs = {12'h000, regRdata};
      1: obs = videoAddr;
      2: obs = {2'h0, dramAddr};
      3: obs = {19'h00000, font3};
      4: obs = {16'h0000, panShift};
      5: obs = {18'h00000, hLock, vLock};
      6: obs = {13'h0000, memCfg};
      7: obs = {14'h0000, vidCfg};
      8: obs = {19'h00000, bg4};
      10: obs = {19'h00000, ma8};
      default: obs = {19'h00000, dramAddr[0]};
    endcase
  endfunction

  // Read data is registered, so it is due one edge after the strobe
  always @(posedge clk) readDue <= regRead;

  always @(negedge clk)
  begin
    if ((readDue === 1'b1 || probe === 1'b1) && notes.size() > 0)
    begin
      note = notes.pop_front();
      testsRun++;
      if (obs(note.id) !== note.exp)
      begin
        errors++;
        $display("CHECK FAILED %s expected %h seen %h", note.name, note.exp, obs(note.id));
      end
    end
  end

  // ----------------------------------------------------------------------
  // Driver helpers
  // ----------------------------------------------------------------------
  // Derived outputs lag one cycle, the host-side DRAM address two; two edges cover the longest path
  task automatic chk(input int id, input logic [19:0] e, input string name);
    repeat (2) @(posedge clk);
    notes.push_back('{id, e, name});
    probe = 1'b1;
    @(posedge clk);
    #1 probe = 1'b0;
  endtask

  task automatic rdx(input logic [7:0] idx, input logic [7:0] e, input string name);
    notes.push_back('{0, {12'h000, e}, name});
    host_u.rd(idx);
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", testsRun, errors);
    if (errors == 0 && testsRun > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Far beyond the few hundred cycles the sequence needs
  initial
  begin
    #(20 * 20000);
    errors++;
    print_verdict();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    void'($urandom(72));
    {page, stdMap, pageSel, modeCtl, r11, cfgBit, att4, crtCycle, probe} = 9'h000;
    {chain, accMode, panValue, errors, testsRun} = '0;
    {hostAddr, charAddr} = '0;
    textMode = 1'b1;
    reset = 1'b1;
    repeat (10) @(posedge clk);
    #1 reset = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    rdx(IDX_MEMORY_SIZE, 8'h01, "strap");
    rdx(IDX_VIDEO_SELECT, 8'h00, "vsel reset");
    host_u.wr(IDX_VIDEO_SELECT, 8'h18);
    rdx(IDX_VIDEO_SELECT, 8'h00, "locked write");
    host_u.unlock();
    host_u.wr(IDX_PRIMARY_OFFSET, 8'hFF);
    rdx(IDX_PRIMARY_OFFSET, 8'h7F, "offset bit7");
    // Every size code and host map code, then the standard override
    for (int k = 0; k < 5; k++)
    begin
      v = 8'($urandom);
      v[7:6] = 2'(k);
      v[5:4] = 2'(k);
      stdMap = (k == 4);
      host_u.wr(IDX_MEMORY_SIZE, v);
      rdx(IDX_MEMORY_SIZE, v, "size readback");
      if (k < 4)
        chk(6, {v[5:0], stdMap}, "mem cfg");
      else
        chk(6, {2'b00, v[3:0], 1'b1}, "override");
    end
    stdMap = 1'b0;
    // Width codes, clock select and horizontal rate
    for (int k = 0; k < 8; k++)
    begin
      v = 8'($urandom);
      v[4:3] = 2'(k);
      cfgBit = k[0];
      textMode = ~k[2];
      host_u.wr(IDX_VIDEO_SELECT, v);
      if (!textMode)
        v[4:3] = 2'b00; // Width codes have no effect outside text
      chk(7, {v[4:2], v[1] & cfgBit, v[1] & ~cfgBit, v[0]}, "vid cfg");
    end
    textMode = 1'b1;
    // Font plane and background bit for all map, underline, attribute mixes
    for (int i = 0; i < 8; i++)
    begin
      att4 = i[0];
      host_u.wr(IDX_VIDEO_SELECT, {2'b00, i[2], 2'b00, i[1], 2'b00});
      chk(3, {19'h00000, i[2] & (~i[1] | i[0])}, "font plane");
      chk(8, {19'h00000, ~i[1] & i[0]}, "bg bit");
    end
    page = 1'b1;
    chk(3, 20'h00000, "page mode");
    page = 1'b0;
    // Ten-dot panning table
    host_u.wr(IDX_VIDEO_SELECT, 8'h18);
    for (int p = 0; p < 10; p++)
    begin
      panValue = 4'(p);
      chk(4, (p == 9) ? 20'h00000 : (p == 8) ? 20'h00001 : 20'(p + 2), "pan");
    end
    // Lock outputs from lock bits 5 and 0 and register 11 bit 7; bit 1 is driven too
    for (int i = 0; i < 16; i++)
    begin
      r11 = i[3];
      host_u.wr(IDX_CRT_LOCK, {2'b00, i[2], 3'b000, i[1], i[0]});
      chk(5, {18'h00000, i[2] | i[3], i[0] | i[3]}, "locks");
    end
    r11 = 1'b0;
    // Offset windows chosen by host bit 15
    ofsA = 8'($urandom) & 8'h7F;
    ofsB = 8'($urandom) & 8'h7F;
    host_u.wr(IDX_MEMORY_SIZE, 8'hF8);
    host_u.wr(IDX_PRIMARY_OFFSET, ofsA);
    host_u.wr(IDX_ALTERNATE_OFFSET, ofsB);
    for (int a = 0; a < 2; a++)
    begin
      hostAddr = 20'($urandom);
      hostAddr[15] = a[0];
      exp20 = hostAddr + {1'b0, (a == 1) ? ofsA[6:0] : ofsB[6:0], 12'h000};
      chk(1, exp20, "video addr");
    end
    // Large-memory organisation for each width, host and display side
    host_u.wr(IDX_PRIMARY_OFFSET, 8'h00);
    host_u.wr(IDX_MEMORY_SIZE, 8'hF0);
    for (int i = 0; i < 6; i++)
    begin
      accMode = 2'(i % 3);
      crtCycle = (i > 2);
      hostAddr = 20'($urandom);
      charAddr = 18'($urandom);
      case (i)
        0: chk(2, {2'b00, hostAddr[17:0]}, "byte host");
        1: chk(2, {2'b00, hostAddr[17:1], hostAddr[18]}, "word host");
        2: chk(2, {2'b00, hostAddr[17:2], hostAddr[19:18]}, "dword host");
        3: chk(2, {2'b00, charAddr}, "byte crt");
        4: chk(2, {2'b00, charAddr[16:0], charAddr[17]}, "word crt");
        default: chk(2, {2'b00, charAddr[15:0], charAddr[17:16]}, "dword crt");
      endcase
      if (i == 0)
        chk(10, {19'h00000, hostAddr[8]}, "high addr pin");
    end
    // Mid-size organisation: bank select follows host bit 16
    host_u.wr(IDX_MEMORY_SIZE, 8'hA0);
    {accMode, crtCycle} = 3'b000;
    hostAddr = 20'($urandom);
    chk(10, {19'h00000, hostAddr[16]}, "bank select");
    // Standard organisation, word mode, low address bit source
    host_u.wr(IDX_MEMORY_SIZE, 8'h00);
    accMode = 2'b01;
    for (int i = 0; i < 8; i++)
    begin
      crtCycle = i[2];
      chain = {i[1], 1'b0};
      modeCtl = i[1];
      pageSel = i[0];
      hostAddr = 20'($urandom);
      charAddr = 18'($urandom);
      if (i < 4)
        chk(9, {19'h00000, i[1] ? i[0] : hostAddr[16]}, "host bit0");
      else
        chk(9, {19'h00000, i[1] ? charAddr[15] : charAddr[13]}, "crt bit0");
    end
    // Relock with another key, then read protection
    host_u.wr(IDX_UNLOCK, 8'h04);
    host_u.wr(IDX_VIDEO_SELECT, 8'hFF);
    rdx(IDX_VIDEO_SELECT, 8'h18, "relocked");
    host_u.unlock();
    host_u.wr(IDX_CRT_LOCK, 8'h21);
    host_u.wr(IDX_VIDEO_CONTROL, 8'h02);
    rdx(IDX_VIDEO_SELECT, 8'h00, "read protect");
    rdx(8'h20, 8'h00, "unmapped");
    repeat (3) @(posedge clk);
    print_verdict();
  end
endmodule // video_memory_config_regs_test

/* File: vmcfg_host_model.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Host side of the indexed data port plus the board strap resistors
// ----------------------------------------------------------------------
module vmcfg_host_model
  import vmcfg_pkg::*;
(
  input  wire logic       clk,
  output logic      [7:0] regIndex,
  output logic            regWrite,
  output logic            regRead,
  output logic      [7:0] regWdata,
  output logic      [1:0] memory_data_pins
);
  // Pull-up on pin 1 only, so the two latched bits must differ
  initial
  begin
    memory_data_pins = 2'b10;
    regIndex = 8'h00;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
  end

  // Released index and data lines show the inverse, not the old value
  task automatic release_bus();
    regIndex = ~regIndex;
    regWdata = ~regWdata;
  endtask

  // One write cycle, request held across the sampling edge
  task automatic wr(input logic [7:0] idx, input logic [7:0] data);
    @(posedge clk);
    #1 regIndex = idx;
    regWdata = data;
    regWrite = 1'b1;
    @(posedge clk);
    #1 regWrite = 1'b0;
    release_bus();
  endtask

  // One read cycle; data is taken by the watcher after this edge
  task automatic rd(input logic [7:0] idx);
    @(posedge clk);
    #1 regIndex = idx;
    regRead = 1'b1;
    @(posedge clk);
    #1 regRead = 1'b0;
    release_bus();
  endtask

  // Low bits 101 open the extended group for writing
  task automatic unlock();
    wr(IDX_UNLOCK, 8'h05);
  endtask
endmodule // vmcfg_host_model

/* File: vmcfg_pkg.sv */
package vmcfg_pkg;

  // ----------------------------------------------------------------------
  // Register indexes on the graphics data port
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_PRIMARY_OFFSET   = 8'h09;
  localparam logic [7:0] IDX_ALTERNATE_OFFSET = 8'h0A;
  localparam logic [7:0] IDX_MEMORY_SIZE      = 8'h0B;
  localparam logic [7:0] IDX_VIDEO_SELECT     = 8'h0C;
  localparam logic [7:0] IDX_CRT_LOCK         = 8'h0D;
  localparam logic [7:0] IDX_VIDEO_CONTROL    = 8'h0E;
  localparam logic [7:0] IDX_UNLOCK           = 8'h0F;

  // ----------------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_RESET_VALUE   = 8'h00;
  localparam logic [2:0] UNLOCK_KEY        = 3'h5;
  localparam int         MSZ_ALT_EN_BIT    = 3;
  localparam int         MSZ_BUS16_BIT     = 2;
  localparam int         MSZ_ROM16_BIT     = 1;
  localparam int         MSZ_ROM_OFF_BIT   = 0;
  localparam int         VSL_MAP_SEL_BIT   = 5;
  localparam int         VSL_UNDERLINE_BIT = 2;
  localparam int         VSL_CLK_SEL_BIT   = 1;
  localparam int         VSL_HRATE_BIT     = 0;
  localparam int         LCK_HORIZ_BIT     = 5;
  localparam int         LCK_GROUP1_BIT    = 1;
  localparam int         LCK_VERT_BIT      = 0;
  localparam int         VCT_READ_PROT_BIT = 1;

  // Installed memory size codes
  typedef enum logic [1:0] {MEM_STD256, MEM_EXT256, MEM_EXT512, MEM_EXT1024} vmcfg_size_t;

  // Host access width mode
  typedef enum logic [1:0] {ACC_BYTE, ACC_WORD, ACC_DWORD, ACC_RSVD} vmcfg_acc_t;

  // Decoded configuration outputs
  typedef struct packed {
    logic [1:0] hostMap;
    logic       altOffsetEn;
    logic       bus16En;
    logic       rom16En;
    logic       romMappedOut;
    logic       standardMap;
  } vmcfg_mem_cfg_t;

  typedef struct packed {
    logic [1:0] charWidth;
    logic       underlineEn;
    logic       clockSel2;
    logic       clockMuxFreeze;
    logic       horizHighRate;
  } vmcfg_vid_cfg_t;

endpackage : vmcfg_pkg
